/* File: logic/sfamc_ctrl.sv */
// Purpose: Address width selection, bank register and reset handling of a serial NOR flash
// Assumes: spi_sck runs only inside frames; spi_cs_n high at least 400 ns between frames
// Notes: Link logic on spi_sck, registers on ref_clk; one event crosses per frame
//
// Overview of operation
// - Eight-bit volatile bank: low bits give A30..A24, top bit selects four-byte mode.
// - Top bank bit set: every addressed command carries a four-byte address.
// - Top bank bit clear: three-byte address, bank bits choose the 128-Mbit segment.
// - Command 16h reads the bank, 17h with one data byte writes it.
// - Dedicated four-byte commands take four address bytes; later continuous read frames follow the top bank bit.
// - Hardware reset, soft reset or power cycle clear four-byte mode.
// - F0h performs soft reset; host leaves continuous read mode first.
// - Status register write needs a prior 06h write enable, else rejected.
// - Command 05h returns status, bit 0 is one while busy.
// - Mode byte 00h ends continuous read mode when the current read ends.

`timescale 1ns/10ps
`default_nettype none

module sfamc_ctrl
	import sfamc_pkg::*;
#(
	parameter int BUSY_CYC = WRSR_BUSY_CYC
) (
	// Core clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Serial link
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe,
	// Array address
	output logic [31:0] array_addr,
	output logic array_addr_valid,
	// Status
	output logic four_byte_mode,
	output logic cont_read_mode,
	output logic busy_flag,
	output logic write_enable_latch
);

	function automatic logic [31:0] form_addr(input logic four, input logic [31:0] raw,
		input logic [7:0] bank);
		form_addr = four ? raw : {1'b0, bank[6:0], raw[23:0]};
	endfunction

	// Link domain state
	sfamc_link_e state_r, state_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [2:0] acnt_r, acnt_nxt;
	logic four_r, four_nxt;
	logic [31:0] raw_r, raw_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic req_r, req_nxt;
	logic [2:0] ev_code_r, ev_code_nxt;
	logic [7:0] ev_data_r, ev_data_nxt;
	logic [31:0] ev_addr_r, ev_addr_nxt;
	logic so_r, so_nxt;
	logic so_oe_r, so_oe_nxt;
	logic [16:0] sy1_r, sy2_r;
	logic [7:0] bank_s, stat_s;
	logic cont_s;
	logic [7:0] sh;
	logic byte_done;
	logic quad;

	// Core domain state
	logic [7:0] bank_r, bank_nxt;
	logic wel_r, wel_nxt;
	logic [5:0] sr_nv_r, sr_nv_nxt;
	logic [15:0] busy_cnt_r, busy_cnt_nxt;
	logic cont_r, cont_nxt;
	logic pend_r, pend_nxt;
	logic [31:0] addr_out_r, addr_out_nxt;
	logic addr_vld_r, addr_vld_nxt;
	logic busy_r, busy_nxt;
	logic cs_s1_r, cs_s2_r, cs_s3_r;
	logic req_s1_r, req_s2_r;
	logic ev_take, frame_end;
	logic [7:0] stat_byte;

	assign bank_s = sy2_r[7:0];
	assign stat_s = sy2_r[15:8];
	assign cont_s = sy2_r[16];
	assign sh = {shift_r[6:0], spi_si};
	assign byte_done = (bit_cnt_r == BIT_LAST);
	assign quad = (cmd_r == CMD_QREAD) || (cmd_r == CMD_QREAD4);

	// Link decode
	always_comb begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r + 3'h1;
		shift_nxt = sh;
		cmd_nxt = cmd_r;
		acnt_nxt = acnt_r;
		four_nxt = four_r;
		raw_nxt = raw_r;
		tx_nxt = tx_r;
		// Event flag stands until the next frame starts, so it outlives the frame end
		req_nxt = ((state_r == L_CMD) && (bit_cnt_r == 3'h0)) ? 1'b0 : req_r;
		ev_code_nxt = ev_code_r;
		ev_data_nxt = ev_data_r;
		ev_addr_nxt = ev_addr_r;
		case (state_r)
			L_CMD: begin
				if (byte_done) begin
					if (cont_s) begin
						// First byte of a continuous read frame is address
						four_nxt = bank_s[BANK_4B_BIT];
						cmd_nxt = four_nxt ? CMD_QREAD4 : CMD_QREAD;
						raw_nxt = {24'h000000, sh};
						acnt_nxt = (four_nxt ? ADDR4_BYTES : ADDR3_BYTES) - ADDR_ONE;
						state_nxt = L_ADDR;
					end else begin
						cmd_nxt = sh;
						raw_nxt = 32'h00000000;
						case (sh)
							CMD_WREN: begin
								ev_code_nxt = EV_WREN;
								req_nxt = 1'b1;
								state_nxt = L_IGN;
							end
							CMD_WRDI: begin
								ev_code_nxt = EV_WRDI;
								req_nxt = 1'b1;
								state_nxt = L_IGN;
							end
							CMD_SRST: begin
								ev_code_nxt = EV_SRST;
								req_nxt = 1'b1;
								state_nxt = L_IGN;
							end
							CMD_RDSR: begin
								tx_nxt = stat_s;
								state_nxt = L_DOUT;
							end
							CMD_RDBANK: begin
								tx_nxt = bank_s;
								state_nxt = L_DOUT;
							end
							CMD_WRSR, CMD_WRBANK: begin
								state_nxt = L_DIN;
							end
							CMD_READ, CMD_QREAD: begin
								four_nxt = bank_s[BANK_4B_BIT];
								acnt_nxt = four_nxt ? ADDR4_BYTES : ADDR3_BYTES;
								state_nxt = L_ADDR;
							end
							CMD_READ4, CMD_QREAD4: begin
								four_nxt = 1'b1;
								acnt_nxt = ADDR4_BYTES;
								state_nxt = L_ADDR;
							end
							default: begin
								state_nxt = L_IGN;
							end
						endcase
					end
				end
			end
			L_ADDR: begin
				if (byte_done) begin
					raw_nxt = {raw_r[23:0], sh};
					acnt_nxt = acnt_r - ADDR_ONE;
					if (acnt_r == ADDR_ONE) begin
						ev_addr_nxt = form_addr(four_r, raw_nxt, bank_s);
						if (quad) begin
							state_nxt = L_MODE;
						end else begin
							ev_code_nxt = EV_ADDR;
							req_nxt = 1'b1;
							tx_nxt = TX_ERASED;
							state_nxt = L_DOUT;
						end
					end
				end
			end
			L_MODE: begin
				if (byte_done) begin
					ev_code_nxt = EV_QADDR;
					ev_data_nxt = sh;
					req_nxt = 1'b1;
					tx_nxt = TX_ERASED;
					state_nxt = L_DOUT;
				end
			end
			L_DIN: begin
				if (byte_done) begin
					ev_code_nxt = (cmd_r == CMD_WRBANK) ? EV_WRBANK : EV_WRSR;
					ev_data_nxt = sh;
					req_nxt = 1'b1;
					state_nxt = L_IGN;
				end
			end
			L_DOUT: begin
				state_nxt = L_DOUT;
			end
			L_IGN: begin
				state_nxt = L_IGN;
			end
			default: begin
				state_nxt = L_IGN;
			end
		endcase
	end

	// Link control, cleared while the frame is closed
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			state_r <= L_CMD;
			bit_cnt_r <= 3'h0;
			shift_r <= 8'h00;
			cmd_r <= 8'h00;
			acnt_r <= 3'h0;
			four_r <= 1'b0;
			raw_r <= 32'h00000000;
			tx_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			cmd_r <= cmd_nxt;
			acnt_r <= acnt_nxt;
			four_r <= four_nxt;
			raw_r <= raw_nxt;
			tx_r <= tx_nxt;
		end
	end

	// Event payload held across the frame end
	always_ff @(posedge spi_sck) begin
		req_r <= req_nxt;
		ev_code_r <= ev_code_nxt;
		ev_data_r <= ev_data_nxt;
		ev_addr_r <= ev_addr_nxt;
		sy1_r <= {cont_r, stat_byte, bank_r};
		sy2_r <= sy1_r;
	end

	// Serial output on the falling edge
	always_comb begin
		so_oe_nxt = (state_r == L_DOUT);
		so_nxt = tx_r[~bit_cnt_r];
	end

	always_ff @(negedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_r <= so_nxt;
			so_oe_r <= so_oe_nxt;
		end
	end

	// Core side
	// Event taken once per frame, at the synchronised frame end
	assign ev_take = frame_end && req_s2_r;
	assign frame_end = cs_s2_r && !cs_s3_r;
	assign stat_byte = {sr_nv_r, wel_r, busy_r};

	always_comb begin
		bank_nxt = bank_r;
		wel_nxt = wel_r;
		sr_nv_nxt = sr_nv_r;
		busy_cnt_nxt = busy_cnt_r;
		pend_nxt = pend_r;
		addr_out_nxt = addr_out_r;
		addr_vld_nxt = 1'b0;
		if (busy_cnt_r != 16'h0000) begin
			busy_cnt_nxt = busy_cnt_r - 16'h0001;
			if (busy_cnt_r == 16'h0001) begin
				wel_nxt = 1'b0;
			end
		end
		if (ev_take) begin
			case (ev_code_r)
				EV_WREN: begin
					wel_nxt = (busy_cnt_r == 16'h0000) ? 1'b1 : wel_r;
				end
				EV_WRDI: begin
					wel_nxt = 1'b0;
				end
				EV_WRSR: begin
					if (wel_r && (busy_cnt_r == 16'h0000)) begin
						sr_nv_nxt = ev_data_r[7:2];
						busy_cnt_nxt = BUSY_CYC[15:0];
					end
				end
				EV_WRBANK: begin
					bank_nxt = ev_data_r;
				end
				EV_SRST: begin
					bank_nxt = BANK_RST;
					wel_nxt = 1'b0;
					busy_cnt_nxt = 16'h0000;
					pend_nxt = 1'b0;
				end
				EV_ADDR: begin
					addr_out_nxt = ev_addr_r;
					addr_vld_nxt = 1'b1;
				end
				EV_QADDR: begin
					addr_out_nxt = ev_addr_r;
					addr_vld_nxt = 1'b1;
					if (ev_data_r == MODE_EXIT) begin
						pend_nxt = 1'b0;
					end else if (ev_data_r[7:4] == MODE_CONT_NIB) begin
						pend_nxt = 1'b1;
					end
				end
				default: begin
					pend_nxt = pend_r;
				end
			endcase
		end
		cont_nxt = (ev_take && (ev_code_r == EV_SRST)) ? 1'b0 : cont_r;
		if (frame_end) begin
			cont_nxt = pend_nxt;
		end
		busy_nxt = (busy_cnt_nxt != 16'h0000);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bank_r <= BANK_RST;
			wel_r <= 1'b0;
			sr_nv_r <= SR_NV_RST;
			busy_cnt_r <= 16'h0000;
			cont_r <= 1'b0;
			pend_r <= 1'b0;
			addr_out_r <= 32'h00000000;
			addr_vld_r <= 1'b0;
			busy_r <= 1'b0;
			cs_s1_r <= 1'b1;
			cs_s2_r <= 1'b1;
			cs_s3_r <= 1'b1;
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
		end else begin
			bank_r <= bank_nxt;
			wel_r <= wel_nxt;
			sr_nv_r <= sr_nv_nxt;
			busy_cnt_r <= busy_cnt_nxt;
			cont_r <= cont_nxt;
			pend_r <= pend_nxt;
			addr_out_r <= addr_out_nxt;
			addr_vld_r <= addr_vld_nxt;
			busy_r <= busy_nxt;
			cs_s1_r <= spi_cs_n;
			cs_s2_r <= cs_s1_r;
			cs_s3_r <= cs_s2_r;
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
		end
	end

	// Outputs
	assign spi_so = so_r;
	assign spi_so_oe = so_oe_r;
	assign array_addr = addr_out_r;
	assign array_addr_valid = addr_vld_r;
	assign four_byte_mode = bank_r[BANK_4B_BIT];
	assign cont_read_mode = cont_r;
	assign busy_flag = busy_r;
	assign write_enable_latch = wel_r;

endmodule

`default_nettype wire

/* File: logic/sfamc_pkg.sv */
// Purpose: Shared constants and types for the serial flash address mode control block
// Assumes: Single-line serial command interface, mode 0 framing
// Notes: Command codes, status bit positions and busy timing live here

`default_nettype none

package sfamc_pkg;

	// Command codes
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RDSR = 8'h05;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_READ4 = 8'h13;
	localparam logic [7:0] CMD_RDBANK = 8'h16;
	localparam logic [7:0] CMD_WRBANK = 8'h17;
	localparam logic [7:0] CMD_QREAD = 8'hEB;
	localparam logic [7:0] CMD_QREAD4 = 8'hEC;
	localparam logic [7:0] CMD_SRST = 8'hF0;

	// Continuous read mode byte values
	localparam logic [7:0] MODE_EXIT = 8'h00;
	localparam logic [3:0] MODE_CONT_NIB = 4'hA;

	// Register fields and reset values
	localparam int BANK_4B_BIT = 7;
	localparam int SR_BUSY_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam logic [7:0] BANK_RST = 8'h00;
	localparam logic [5:0] SR_NV_RST = 6'h00;
	localparam logic [7:0] TX_ERASED = 8'hFF;

	// Frame counters
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] ADDR3_BYTES = 3'h3;
	localparam logic [2:0] ADDR4_BYTES = 3'h4;
	localparam logic [2:0] ADDR_ONE = 3'h1;

	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRSR_BUSY_NS = 2000;
	localparam int WRSR_BUSY_CYC = (WRSR_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		L_CMD = 3'h0,
		L_ADDR = 3'h1,
		L_MODE = 3'h3,
		L_DOUT = 3'h2,
		L_DIN = 3'h6,
		L_IGN = 3'h7
	} sfamc_link_e;

	typedef enum logic [2:0] {
		EV_WREN = 3'h0,
		EV_WRDI = 3'h1,
		EV_WRSR = 3'h2,
		EV_WRBANK = 3'h3,
		EV_SRST = 3'h4,
		EV_ADDR = 3'h5,
		EV_QADDR = 3'h6
	} sfamc_ev_e;

endpackage

`default_nettype wire

/* File: test/sfamc_ctrl_checker.sv */
// Purpose: Port assertions for sfamc_ctrl
// Assumes: All checks in the ref_clk domain
// Notes: Bound to every sfamc_ctrl instance
`timescale 1ns/10ps
`default_nettype none
module sfamc_ctrl_checker #(
	parameter int BUSY_CYC = 4
) (
	// Core
	input wire logic ref_clk,
	input wire logic rst_n,
	// Link
	input wire logic spi_cs_n,
	input wire logic spi_so_oe,
	// Array address and status
	input wire logic [31:0] array_addr,
	input wire logic array_addr_valid,
	input wire logic four_byte_mode,
	input wire logic busy_flag,
	input wire logic write_enable_latch
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Busy length counter
	always_comb begin
		cnt_nxt = busy_flag ? cnt_r + 8'h01 : 8'h00;
	end
	always_ff @(posedge ref_clk) begin
		cnt_r <= rst_n ? cnt_nxt : 8'h00;
	end
	a_reset_mode: assert property ($rose(rst_n) |-> !four_byte_mode)
		else $error("four byte mode set after reset");
	a_reset_status: assert property ($rose(rst_n) |-> !busy_flag && !write_enable_latch)
		else $error("status set after reset");
	a_oe_idle: assert property (spi_cs_n |-> !spi_so_oe)
		else $error("output enabled outside frame");
	a_busy_needs_wel: assert property ($rose(busy_flag) |-> write_enable_latch)
		else $error("busy without write enable");
	a_busy_end_wel: assert property ($fell(busy_flag) |-> !write_enable_latch)
		else $error("write enable kept after busy");
	a_busy_len: assert property ($fell(busy_flag) |-> cnt_r == BUSY_CYC[7:0])
		else $error("busy length wrong");
	a_addr_with_valid: assert property ($changed(array_addr) |-> array_addr_valid)
		else $error("address changed without valid");
	a_valid_pulse: assert property (array_addr_valid |=> !array_addr_valid)
		else $error("valid longer than one cycle");
endmodule
bind sfamc_ctrl sfamc_ctrl_checker #(.BUSY_CYC(BUSY_CYC)) u_sfamc_ctrl_checker (.ref_clk,
	.rst_n, .spi_cs_n, .spi_so_oe, .array_addr, .array_addr_valid, .four_byte_mode,
	.busy_flag, .write_enable_latch);
`default_nettype wire

/* File: test/sfamc_ctrl_tb.sv */
// Purpose: Self-checking bench for sfamc_ctrl
// Assumes: Busy lengthened to 40 cycles
// Notes: Frames come from the host model
`timescale 1ns/10ps
`default_nettype none
module sfamc_ctrl_tb
	import sfamc_pkg::*;
;
	logic ref_clk, rst_n, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, array_addr_valid;
	logic four_byte_mode, cont_read_mode, busy_flag, write_enable_latch;
	logic [31:0] array_addr;
	logic [7:0] rx;
	int n_mismatch, tests_run;
	sfamc_ctrl #(.BUSY_CYC(40)) u_sfamc_ctrl (.ref_clk, .rst_n, .spi_sck, .spi_cs_n,
		.spi_si, .spi_so, .spi_so_oe, .array_addr, .array_addr_valid, .four_byte_mode,
		.cont_read_mode, .busy_flag, .write_enable_latch);
	sfamc_host u_sfamc_host (.spi_sck, .spi_cs_n, .spi_si, .spi_so);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t byte %h exp %h", $time, got, exp);
		end
	endtask
	task chk_addr(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t addr %h exp %h", $time, got, exp);
		end
	endtask
	task fr(input logic [63:0] tx, input int n);
		u_sfamc_host.xfer(tx, n, rx);
	endtask
	task stop_test;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#500000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		rst_n = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		fr({CMD_RDBANK, 8'h00}, 16);
		chk_byte(rx, BANK_RST);
		fr({CMD_WRBANK, 8'h85}, 16);
		fr({CMD_RDBANK, 8'h00}, 16);
		chk_byte(rx, 8'h85);
		chk_byte({7'h00, four_byte_mode}, 8'h01);
		fr({CMD_READ, 32'h12345678}, 40);
		chk_addr(array_addr, 32'h12345678);
		fr({CMD_WRBANK, 8'h05}, 16);
		fr({CMD_READ, 24'hABCDEF}, 32);
		chk_addr(array_addr, 32'h05ABCDEF);
		fr({CMD_READ4, 32'h87654321}, 40);
		chk_addr(array_addr, 32'h87654321);
		fr({CMD_QREAD, 24'h000100, 8'hA0}, 40);
		chk_byte({7'h00, cont_read_mode}, 8'h01);
		fr({24'h000200, MODE_EXIT}, 32);
		chk_byte({7'h00, cont_read_mode}, 8'h00);
		chk_addr(array_addr, 32'h05000200);
		fr({CMD_WRSR, 8'hFC}, 16);
		fr({CMD_RDSR, 8'h00}, 16);
		chk_byte(rx, 8'h00);
		fr(CMD_WREN, 8);
		fr({CMD_RDSR, 8'h00}, 16);
		chk_byte(rx, 8'h02);
		fr({CMD_WRSR, 8'hFC}, 16);
		fr({CMD_RDSR, 8'h00}, 16);
		chk_byte(rx & 8'h03, 8'h03);
		repeat (2) fr({CMD_RDSR, 8'h00}, 16);
		chk_byte(rx, 8'hFC);
		fr({CMD_WRBANK, 8'h85}, 16);
		fr(CMD_SRST, 8);
		chk_byte({7'h00, four_byte_mode}, 8'h00);
		fr({CMD_RDBANK, 8'h00}, 16);
		chk_byte(rx, 8'h00);
		fr({CMD_RDSR, 8'h00}, 16);
		chk_byte(rx, 8'hFC);
		fr({CMD_WRBANK, 8'h80}, 16);
		@(negedge ref_clk);
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk_byte({7'h00, four_byte_mode}, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire

/* File: test/sfamc_host.sv */
// Purpose: Host serial controller model for sfamc_ctrl
// Assumes: Mode 0, 80 ns link clock, clock still between frames
// Notes: Data line driven inverted after release
`timescale 1ns/10ps
`default_nettype none
module sfamc_host (
	// Link out
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si,
	// Link in
	input wire logic spi_so
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// One frame, n bits MSB first, last byte read back
	task automatic xfer(input logic [63:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		spi_cs_n = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--) begin
			spi_si = tx[i];
			#40 spi_sck = 1'b1;
			rx = {rx[6:0], spi_so};
			#40 spi_sck = 1'b0;
		end
		#40 spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		#400;
	endtask
endmodule
`default_nettype wire
